// ===== design/bitop_exec.sv
// decode and execution of bit clear and bit set over four-phase instruction cycles
`timescale 1ns/10ps
// Function
// - file operand is seven bits, addressing 0x00 through 0x7F.
// - bit-select operand picks one of eight bits in the file register.
// - destination bit is not used: bit clear and bit set always write the addressed file register, never the accumulator.
// - every instruction finishes in one instruction cycle unless two-cycle case applies.
// - true condition or program-counter change costs two cycles, second is a no-op.
// - one instruction cycle is exactly four oscillator periods.
module bitop_exec (
  input  wire logic                          clock_i,
  input  wire logic                          rst_i,
  input  wire logic [bitop_pkg::IW_W-1:0]    instr_i,
  input  wire logic                          instr_valid_i,
  input  wire logic                          flush_i,
  input  wire logic [bitop_pkg::DATA_W-1:0]  file_rdata_i,
  output bitop_pkg::bitop_phase_t            phase_o,
  output bitop_pkg::bitop_file_t             file_o,
  output logic                               acc_wr_o,
  output logic [bitop_pkg::DATA_W-1:0]       acc_wdata_o,
  output logic                               status_wr_o,
  output logic                               retire_o,
  output logic                               nop_cycle_o
);
  import bitop_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  bitop_phase_t         phase_w;
  bitop_phase_t         phase_reg;
  bitop_dec_t           dec_reg;
  bitop_dec_t           dec_next;
  logic                 active_reg;
  logic                 active_next;
  logic                 nop_reg;
  logic                 nop_next;
  logic                 flush_pend_reg;
  logic                 flush_pend_next;
  bitop_file_t          file_reg;
  bitop_file_t          file_next;
  logic                 acc_wr_reg;
  logic                 acc_wr_next;
  logic [DATA_W-1:0]    acc_wdata_reg;
  logic [DATA_W-1:0]    acc_wdata_next;
  logic                 retire_reg;
  logic                 retire_next;
  logic                 nop_out_reg;
  logic                 nop_out_next;
  logic [DATA_W-1:0]    modified;

  bitop_qgen #(
    .PERIODS (OSC_PER_CYC)
  ) u_qgen (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .phase_o (phase_w)
  );

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  // only the opcode nibble is compared; unused positions are never looked at
  function automatic bitop_dec_t decode(input logic [IW_W-1:0] iw);
    bitop_dec_t d;
    d.kind      = BITOP_K_NONE;
    d.bit_sel   = iw[BSEL_HI:BSEL_LO];
    d.file_addr = iw[ADDR_HI:ADDR_LO];
    d.dest_sel  = iw[DSEL_POS];
    if (iw[OPC_HI:OPC_LO] == OPC_CLEAR)
    begin
      d.kind     = BITOP_K_CLEAR;
      d.dest_sel = DEST_FILE;
    end
    else if (iw[OPC_HI:OPC_LO] == OPC_SET)
    begin
      d.kind     = BITOP_K_SET;
      d.dest_sel = DEST_FILE;
    end
    return d;
  endfunction : decode

  // ---------------------------------------------------------------------------
  // bit modify
  // ---------------------------------------------------------------------------
  // one lane per bit; only the selected lane is forced
  genvar gi;
  for (gi = 0; gi < DATA_W; gi++)
  begin : g_lane
    always_comb
    begin
      if (dec_reg.bit_sel == BSEL_W'(gi))
        modified[gi] = (dec_reg.kind == BITOP_K_SET);
      else
        modified[gi] = file_rdata_i[gi];
    end
  end

  // ---------------------------------------------------------------------------
  // sequencing over the quarter phases
  // ---------------------------------------------------------------------------
  // q1 captures the word, q2 shows the read, q3 samples data, q4 shows the write
  always_comb
  begin
    dec_next        = dec_reg;
    active_next     = active_reg;
    nop_next        = nop_reg;
    file_next       = file_reg;
    file_next.rd    = 1'b0;
    file_next.wr    = 1'b0;
    acc_wr_next     = 1'b0;
    acc_wdata_next  = acc_wdata_reg;
    retire_next     = 1'b0;
    nop_out_next    = 1'b0;
    // a flush in the capture phase still counts for the following cycle
    flush_pend_next = flush_pend_reg | flush_i;
    unique case (phase_w)
      BITOP_Q1:
      begin
        dec_next        = decode(instr_i);
        nop_next        = flush_pend_reg;
        active_next     = instr_valid_i & ~flush_pend_reg;
        flush_pend_next = flush_i;
        file_next.addr  = instr_i[ADDR_HI:ADDR_LO];
        file_next.rd    = instr_valid_i & ~flush_pend_reg
                          & (dec_next.kind != BITOP_K_NONE);
      end
      BITOP_Q2:
      begin
        file_next.rd = 1'b0;
      end
      BITOP_Q3:
      begin
        if (active_reg && dec_reg.kind != BITOP_K_NONE)
        begin
          if (dec_reg.dest_sel == DEST_FILE)
          begin
            file_next.wr    = 1'b1;
            file_next.wdata = modified;
          end
          else
          begin
            acc_wr_next    = 1'b1;
            acc_wdata_next = modified;
          end
        end
      end
      BITOP_Q4:
      begin
        // every taken word retires at the cycle boundary
        retire_next  = active_reg;
        nop_out_next = nop_reg;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      dec_reg        <= '0;
      active_reg     <= 1'b0;
      nop_reg        <= 1'b0;
      flush_pend_reg <= 1'b0;
      file_reg       <= '0;
      acc_wr_reg     <= 1'b0;
      acc_wdata_reg  <= '0;
      retire_reg     <= 1'b0;
      nop_out_reg    <= 1'b0;
      phase_reg      <= BITOP_Q1;
    end
    else
    begin
      dec_reg        <= dec_next;
      active_reg     <= active_next;
      nop_reg        <= nop_next;
      flush_pend_reg <= flush_pend_next;
      file_reg       <= file_next;
      acc_wr_reg     <= acc_wr_next;
      acc_wdata_reg  <= acc_wdata_next;
      retire_reg     <= retire_next;
      nop_out_reg    <= nop_out_next;
      phase_reg      <= phase_w;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, registered except the status strobe, which is tied low
  // ---------------------------------------------------------------------------
  // status is never touched by these operations, so the strobe stays low
  assign phase_o     = phase_reg;
  assign file_o      = file_reg;
  assign acc_wr_o    = acc_wr_reg;
  assign acc_wdata_o = acc_wdata_reg;
  assign status_wr_o = 1'b0;
  assign retire_o    = retire_reg;
  assign nop_cycle_o = nop_out_reg;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // the read must carry the address field of the word captured one edge earlier
  a_addr_in_range: assert property (
    file_o.rd |-> (file_o.addr <= FILE_MAX)
      && (file_o.addr == $past(instr_i[ADDR_HI:ADDR_LO])))
    else $error("file address beyond range");

  a_clear_bit_zero: assert property (
    (phase_w == BITOP_Q3 && active_reg && dec_reg.kind == BITOP_K_CLEAR)
      |=> file_o.wr && !file_o.wdata[dec_reg.bit_sel])
    else $error("bit clear did not zero the bit");

  a_set_bit_one: assert property (
    (phase_w == BITOP_Q3 && active_reg && dec_reg.kind == BITOP_K_SET)
      |=> file_o.wr && file_o.wdata[$past(dec_reg.bit_sel)])
    else $error("bit set did not raise the bit");

  a_other_bits_kept: assert property (
    (phase_w == BITOP_Q3 && active_reg && dec_reg.kind != BITOP_K_NONE)
      |=> ((file_o.wdata ^ $past(file_rdata_i)) & ~(8'h01 << $past(dec_reg.bit_sel))) == 8'h00)
    else $error("unselected bits altered");

  a_dest_file_only: assert property (file_o.wr |-> !acc_wr_o)
    else $error("both destinations written");

  a_read_to_write: assert property (
    (file_o.rd && !flush_pend_reg) |-> ##2 file_o.wr)
    else $error("bit operation not written within its cycle");

  a_retire_one_cycle: assert property (
    file_o.wr |=> retire_o ##1 !retire_o [*3])
    else $error("retire not once per cycle");

  a_flush_makes_nop: assert property (
    (flush_i && phase_w == BITOP_Q1) |-> ##4 (phase_w == BITOP_Q1) ##1 nop_reg && !file_o.rd)
    else $error("flush did not turn next cycle into a no-op");

  a_nop_no_write: assert property (nop_reg |-> !file_o.wr && !acc_wr_o)
    else $error("write during a no-op cycle");

  a_status_quiet: assert property (file_o.wr |-> !status_wr_o)
    else $error("status written by a bit operation");

  a_dontcare_same: assert property (
    (phase_w == BITOP_Q1 && instr_valid_i && !flush_pend_reg
      && instr_i[OPC_HI:OPC_LO] == OPC_SET) |=> dec_reg.kind == BITOP_K_SET
      && dec_reg.dest_sel == DEST_FILE)
    else $error("decode depends on unused bits");

endmodule : bitop_exec

// ===== design/bitop_pkg.sv
// package of constants and types for the bit clear / bit set execution block
package bitop_pkg;

  // ---------------------------------------------------------------------------
  // instruction word layout
  // ---------------------------------------------------------------------------
  localparam int unsigned IW_W        = 14;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned BSEL_W      = 3;
  localparam int unsigned OPC_HI      = 13;
  localparam int unsigned OPC_LO      = 10;
  localparam int unsigned BSEL_HI     = 9;
  localparam int unsigned BSEL_LO     = 7;
  localparam int unsigned ADDR_HI     = 6;
  localparam int unsigned ADDR_LO     = 0;
  localparam int unsigned DSEL_POS    = 7;
  localparam logic [3:0]  OPC_CLEAR   = 4'h4;
  localparam logic [3:0]  OPC_SET     = 4'h5;
  localparam logic [6:0]  FILE_MIN    = 7'h00;
  localparam logic [6:0]  FILE_MAX    = 7'h7f;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned OSC_PER_CYC = 4;

  // destination select values
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // quarter phases, gray along the natural sequence
  typedef enum logic [1:0] {
    BITOP_Q1 = 2'b00,
    BITOP_Q2 = 2'b01,
    BITOP_Q3 = 2'b11,
    BITOP_Q4 = 2'b10
  } bitop_phase_t;

  typedef enum logic [1:0] {
    BITOP_K_NONE  = 2'b00,
    BITOP_K_CLEAR = 2'b01,
    BITOP_K_SET   = 2'b11
  } bitop_kind_t;

  // decoded instruction carried through the cycle
  typedef struct packed {
    bitop_kind_t         kind;
    logic [BSEL_W-1:0]   bit_sel;
    logic [ADDR_W-1:0]   file_addr;
    logic                dest_sel;
  } bitop_dec_t;

  // register-file request bundle
  typedef struct packed {
    logic                rd;
    logic                wr;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } bitop_file_t;

endpackage : bitop_pkg

// ===== design/bitop_qgen.sv
// quarter-phase generator splitting the oscillator into instruction cycles
`timescale 1ns/10ps
module bitop_qgen #(
  parameter int unsigned PERIODS = bitop_pkg::OSC_PER_CYC
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  output bitop_pkg::bitop_phase_t     phase_o
);
  import bitop_pkg::*;

  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  // the phase sequence is a four-state gray ring, so nothing else is served
  if (PERIODS != 4)
  begin : g_bad_periods
    $error("bitop_qgen: PERIODS must be 4");
  end

  bitop_phase_t phase_reg;
  bitop_phase_t phase_next;

  // ---------------------------------------------------------------------------
  // phase ring
  // ---------------------------------------------------------------------------
  // four oscillator periods make one instruction cycle
  always_comb
  begin
    unique case (phase_reg)
      BITOP_Q1: phase_next = BITOP_Q2;
      BITOP_Q2: phase_next = BITOP_Q3;
      BITOP_Q3: phase_next = BITOP_Q4;
      BITOP_Q4: phase_next = BITOP_Q1;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      phase_reg <= BITOP_Q1;
    else
      phase_reg <= phase_next;
  end

  assign phase_o = phase_reg;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_ring_q1_every4: assert property (@(posedge clock_i) disable iff (rst_i)
    (phase_reg == BITOP_Q1) |=> (phase_reg != BITOP_Q1) [*3] ##1 (phase_reg == BITOP_Q1))
    else $error("phase ring is not four periods long");

endmodule : bitop_qgen

// ===== dv/test_bitop_exec.sv
// self-checking testbench for the bit clear / bit set execution block
`timescale 1ns/10ps
module test_bitop_exec;
  import bitop_pkg::*;

  // ---------------------------------------------------------------------------
  // signals and design instance
  // ---------------------------------------------------------------------------
  logic                clock_i       = 1'b0;
  logic                rst_i         = 1'b1;
  logic [IW_W-1:0]     instr_i       = '0;
  logic                instr_valid_i = 1'b0;
  logic                flush_i       = 1'b0;
  logic [DATA_W-1:0]   file_rdata_i  = 8'h00;
  bitop_phase_t        phase_o;
  bitop_file_t         file_o;
  logic                acc_wr_o;
  logic [DATA_W-1:0]   acc_wdata_o;
  logic                status_wr_o;
  logic                retire_o;
  logic                nop_cycle_o;
  int                  n_mismatch    = 0;
  int                  n_checks      = 0;

  bitop_exec DUT (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .instr_i       (instr_i),
    .instr_valid_i (instr_valid_i),
    .flush_i       (flush_i),
    .file_rdata_i  (file_rdata_i),
    .phase_o       (phase_o),
    .file_o        (file_o),
    .acc_wr_o      (acc_wr_o),
    .acc_wdata_o   (acc_wdata_o),
    .status_wr_o   (status_wr_o),
    .retire_o      (retire_o),
    .nop_cycle_o   (nop_cycle_o)
  );

  // 10 MHz oscillator
  always #50 clock_i = ~clock_i;

  // ---------------------------------------------------------------------------
  // compare, report and timing helpers
  // ---------------------------------------------------------------------------
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1

  task automatic chkv(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chkv

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // step one edge, inputs change 1 ns after it
  task automatic tick;
    @(posedge clock_i);
    #1;
  endtask : tick

  // phase_o lags, so Q4 shown means the internal capture cycle is running
  task automatic sync_q1;
    int n = 0;
    do
    begin
      tick();
      n++;
    end
    while (phase_o !== BITOP_Q4 && n < 8);
    // a capture slot never found counts against the run
    chkv({6'h00, phase_o}, {6'h00, BITOP_Q4});
  endtask : sync_q1

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  // one word through a full cycle, read-modify-write checked slot by slot
  task automatic run_op(input logic [3:0] opc, input logic [2:0] b,
                        input logic [6:0] f, input logic [7:0] rdv);
    logic       isbit;
    logic [7:0] wd;
    isbit = (opc === OPC_SET) || (opc === OPC_CLEAR);
    wd = (opc === OPC_SET) ? (rdv | (8'h01 << b)) : (rdv & ~(8'h01 << b));
    sync_q1();
    instr_i = {opc, b, f};
    instr_valid_i = 1'b1;
    file_rdata_i = rdv;
    tick();
    // a stale word on the port after capture must not matter
    instr_valid_i = 1'b0;
    instr_i = ~{opc, b, f};
    chk1(file_o.rd, isbit);
    if (isbit)
      chkv({1'b0, file_o.addr}, {1'b0, f});
    tick();
    chk1(file_o.rd, 1'b0);
    chk1(file_o.wr, 1'b0);
    tick();
    // read data was taken at the edge just passed; inverse exposes a late sample
    file_rdata_i = ~rdv;
    chk1(file_o.wr, isbit);
    if (isbit)
      chkv(file_o.wdata, wd);
    chk1(acc_wr_o, 1'b0);
    chkv(acc_wdata_o, 8'h00);
    chk1(status_wr_o, 1'b0);
    tick();
    chk1(retire_o, 1'b1);
    chk1(file_o.wr, 1'b0);
    chk1(nop_cycle_o, 1'b0);
    tick();
    chk1(retire_o, 1'b0);
  endtask : run_op

  // quarter phases run gray with a period of four edges
  task automatic phase_walk;
    bitop_phase_t seq [4] = '{BITOP_Q1, BITOP_Q2, BITOP_Q3, BITOP_Q4};
    sync_q1();
    for (int i = 0; i < 8; i++)
    begin
      tick();
      chkv({6'h00, phase_o}, {6'h00, seq[i % 4]});
    end
  endtask : phase_walk

  // a word offered outside the capture slot is ignored
  task automatic off_slot;
    int acc = 0;
    sync_q1();
    tick();
    instr_i = {OPC_SET, 3'h1, 7'h10};
    instr_valid_i = 1'b1;
    tick();
    instr_valid_i = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      acc += file_o.rd + retire_o;
      tick();
    end
    chkv(8'(acc), 8'h00);
  endtask : off_slot

  // flush during a bit set: set completes, next cycle is a no-op
  task automatic flush_nop;
    int n_rd = 0;
    int n_wr = 0;
    int n_ret = 0;
    int n_nop = 0;
    sync_q1();
    instr_i = {OPC_SET, 3'h3, 7'h22};
    instr_valid_i = 1'b1;
    flush_i = 1'b1;
    file_rdata_i = 8'h00;
    tick();
    instr_valid_i = 1'b0;
    flush_i = 1'b0;
    for (int k = 1; k < 12; k++)
    begin
      if (k >= 5) n_rd += file_o.rd;
      if (k >= 5) n_wr += file_o.wr;
      if (k >= 6) n_ret += retire_o;
      n_nop += nop_cycle_o;
      if (k == 3) chk1(file_o.wr, 1'b1);
      if (k == 4) chk1(retire_o, 1'b1);
      instr_valid_i = (k == 4);
      instr_i = {OPC_CLEAR, 3'h0, 7'h33};
      tick();
    end
    instr_valid_i = 1'b0;
    chkv(8'(n_rd + n_wr), 8'h00);
    chkv(8'(n_ret), 8'h00);
    chkv(8'(n_nop), 8'h01);
  endtask : flush_nop

  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    chkv({6'h00, phase_o}, {6'h00, BITOP_Q1});
    phase_walk();
    // every bit position, both operations, both address bounds
    for (int b = 0; b < 8; b++)
    begin
      run_op(OPC_SET, 3'(b), FILE_MAX, 8'h0a);
      run_op(OPC_CLEAR, 3'(b), FILE_MIN, 8'hc7);
    end
    run_op(OPC_SET, 3'h7, 7'h55, 8'hff);
    run_op(OPC_CLEAR, 3'h4, 7'h2a, 8'h00);
    run_op(4'h6, 3'h2, 7'h11, 8'h5a);
    off_slot();
    flush_nop();
    run_op(OPC_SET, 3'h0, 7'h01, 8'h80);
    summarize();
  end

  // a hang past many times the expected run length ends the test
  initial
  begin
    #(5000 * 100);
    n_mismatch++;
    summarize();
  end

endmodule : test_bitop_exec
